// ==== verilog/dcfg_top.sv ====
// dcfg_top: data configuration register bank behind an AXI4-Lite slave,
// driving the DMA mode, addressing, loopback and bus request controls.
// assumes one clock, synchronous DMA-side inputs and a well-behaved master.
`timescale 1ns/100ps

module dcfg_top
	import dcfg_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RSTN_I,
	// AXI4-Lite write address
	input wire logic [7:0] AXI_AWADDR_I,
	input wire logic AXI_AWVALID_I,
	output logic AXI_AWREADY_O,
	// AXI4-Lite write data
	input wire logic [31:0] AXI_WDATA_I,
	input wire logic [3:0] AXI_WSTRB_I,
	input wire logic AXI_WVALID_I,
	output logic AXI_WREADY_O,
	// AXI4-Lite write response
	output logic [1:0] AXI_BRESP_O,
	output logic AXI_BVALID_O,
	input wire logic AXI_BREADY_I,
	// AXI4-Lite read address
	input wire logic [7:0] AXI_ARADDR_I,
	input wire logic AXI_ARVALID_I,
	output logic AXI_ARREADY_O,
	// AXI4-Lite read data
	output logic [31:0] AXI_RDATA_O,
	output logic [1:0] AXI_RRESP_O,
	output logic AXI_RVALID_O,
	input wire logic AXI_RREADY_I,
	// receive fifo side
	input wire logic RX_ACTIVE_I,
	input wire logic [4:0] FIFO_BYTES_I,
	output logic BUS_REQUEST_O,
	// DMA mode controls
	output logic WORD_MODE_O,
	output logic BYTE_ORDER_O,
	output logic DUAL_CHANNEL_O,
	output logic [15:0] UPPER_ADDR_O,
	output logic AUTO_INIT_O,
	// loopback controls
	output logic LOOPBACK_O,
	output logic [1:0] LOOPBACK_MODE_O,
	output logic ENDEC_LOOPBACK_O,
	// memory data lanes
	input wire logic [15:0] DMA_DATA_I,
	output logic [15:0] MEM_DATA_O
);
	typedef enum logic [1:0] {DCFG_WR_COLLECT = 2'b01, DCFG_WR_RESP = 2'b10} dcfg_wr_e;
	typedef enum logic [1:0] {DCFG_RD_IDLE = 2'b01, DCFG_RD_RESP = 2'b10} dcfg_rd_e;

	// maps a byte address to a register index, flags a mapped hit
	function automatic logic dcfg_hit(input logic [7:0] addr, input logic [7:0] idx);
		return addr[7:2] == idx[5:0];
	endfunction : dcfg_hit

	function automatic logic dcfg_mapped(input logic [7:0] addr);
		return dcfg_hit(addr, DCFG_IDX_DATA_CONFIG) || dcfg_hit(addr, DCFG_IDX_XMIT_CONFIG) ||
			dcfg_hit(addr, DCFG_IDX_REMOTE_START) || dcfg_hit(addr, DCFG_IDX_COMMAND) ||
			dcfg_hit(addr, DCFG_IDX_STATUS);
	endfunction : dcfg_mapped

	// write channel state
	dcfg_wr_e wr_st_d, wr_st_q;
	logic aw_have_d, aw_have_q, w_have_d, w_have_q, commit;
	logic aw_ready_d, aw_ready_q, w_ready_d, w_ready_q, bvalid_d, bvalid_q;
	logic [7:0] aw_addr_d, aw_addr_q;
	logic [31:0] w_data_d, w_data_q;
	logic [3:0] w_strb_d, w_strb_q;
	logic [1:0] bresp_d, bresp_q;

	// read channel state
	dcfg_rd_e rd_st_d, rd_st_q;
	logic ar_ready_d, ar_ready_q, rvalid_d, rvalid_q;
	logic [31:0] rdata_d, rdata_q;
	logic [1:0] rresp_d, rresp_q;

	// configuration and status
	logic [6:0] config_d, config_q;
	logic [1:0] lb_field_d, lb_field_q;
	logic [15:0] remote_start_d, remote_start_q;
	logic send_ignored_d, send_ignored_q, auto_init_d, auto_init_q;

	// registered mode outputs
	logic word_mode_d, word_mode_q, byte_order_d, byte_order_q, dual_d, dual_q;
	logic loopback_d, loopback_q, endec_d, endec_q, bus_request;
	logic [15:0] upper_d, upper_q;
	logic [1:0] lb_mode_d, lb_mode_q;

	// write path: address and data are taken independently, then committed
	always_comb begin
		wr_st_d = wr_st_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		aw_addr_d = aw_addr_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bresp_d = bresp_q;
		commit = 1'b0;
		case (wr_st_q)
			DCFG_WR_COLLECT: begin
				if (aw_have_q && w_have_q) begin
					commit = 1'b1;
					aw_have_d = 1'b0;
					w_have_d = 1'b0;
					bresp_d = dcfg_mapped(aw_addr_q) ? DCFG_RESP_OKAY : DCFG_RESP_SLVERR;
					wr_st_d = DCFG_WR_RESP;
				end else begin
					if (AXI_AWVALID_I && !aw_have_q) begin
						aw_have_d = 1'b1;
						aw_addr_d = AXI_AWADDR_I;
					end
					if (AXI_WVALID_I && !w_have_q) begin
						w_have_d = 1'b1;
						w_data_d = AXI_WDATA_I;
						w_strb_d = AXI_WSTRB_I;
					end
				end
			end
			DCFG_WR_RESP: begin
				if (AXI_BREADY_I) begin
					wr_st_d = DCFG_WR_COLLECT;
				end
			end
			default: begin
				wr_st_d = DCFG_WR_COLLECT;
			end
		endcase
		// handshake flags are registered so every port comes from a flop
		aw_ready_d = (wr_st_d == DCFG_WR_COLLECT) && !aw_have_d;
		w_ready_d = (wr_st_d == DCFG_WR_COLLECT) && !w_have_d;
		bvalid_d = (wr_st_d == DCFG_WR_RESP);
	end

	// register writes and hardware-set state
	always_comb begin
		config_d = config_q;
		lb_field_d = lb_field_q;
		remote_start_d = remote_start_q;
		send_ignored_d = send_ignored_q;
		auto_init_d = 1'b0;
		if (commit && w_strb_q[0]) begin
			// narrow registers live in lane 0; other lanes are dropped
			if (dcfg_hit(aw_addr_q, DCFG_IDX_DATA_CONFIG)) begin
				config_d = w_data_q[6:0] & DCFG_DATA_CONFIG_MASK;
			end
			if (dcfg_hit(aw_addr_q, DCFG_IDX_XMIT_CONFIG)) begin
				lb_field_d = w_data_q[DCFG_LOOPBACK_FIELD_HIGH:DCFG_LOOPBACK_FIELD_LOW];
			end
			if (dcfg_hit(aw_addr_q, DCFG_IDX_STATUS) && w_data_q[DCFG_ST_SEND_IGNORED]) begin
				send_ignored_d = 1'b0;
			end
			if (dcfg_hit(aw_addr_q, DCFG_IDX_COMMAND) && w_data_q[DCFG_CMD_SEND]) begin
				if (config_q[DCFG_AUTO_INIT_REMOTE]) begin
					auto_init_d = 1'b1;
				end else begin
					// set after the clear so a refused send is never lost
					send_ignored_d = 1'b1;
				end
			end
		end
		if (commit && dcfg_hit(aw_addr_q, DCFG_IDX_REMOTE_START)) begin
			if (w_strb_q[0]) begin
				remote_start_d[7:0] = w_data_q[7:0];
			end
			if (w_strb_q[1]) begin
				remote_start_d[15:8] = w_data_q[15:8];
			end
		end
	end

	// read path; write-only registers read as zero
	always_comb begin
		rd_st_d = rd_st_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		case (rd_st_q)
			DCFG_RD_IDLE: begin
				if (AXI_ARVALID_I) begin
					rd_st_d = DCFG_RD_RESP;
					rdata_d = 32'h0000_0000;
					rresp_d = dcfg_mapped(AXI_ARADDR_I) ? DCFG_RESP_OKAY : DCFG_RESP_SLVERR;
					if (dcfg_hit(AXI_ARADDR_I, DCFG_IDX_REMOTE_START)) begin
						rdata_d = {16'h0000, remote_start_q};
					end
					if (dcfg_hit(AXI_ARADDR_I, DCFG_IDX_STATUS)) begin
						rdata_d[DCFG_ST_SEND_IGNORED] = send_ignored_q;
						rdata_d[DCFG_ST_BUS_REQUEST] = bus_request;
						rdata_d[DCFG_ST_LOOPBACK] = loopback_q;
						rdata_d[DCFG_ST_CONFIG_LSB +: 7] = config_q;
					end
				end
			end
			DCFG_RD_RESP: begin
				if (AXI_RREADY_I) begin
					rd_st_d = DCFG_RD_IDLE;
				end
			end
			default: begin
				rd_st_d = DCFG_RD_IDLE;
			end
		endcase
		ar_ready_d = (rd_st_d == DCFG_RD_IDLE);
		rvalid_d = (rd_st_d == DCFG_RD_RESP);
	end

	// mode outputs decoded from the stored configuration
	always_comb begin
		word_mode_d = config_q[DCFG_WORD_TRANSFER_SELECT];
		byte_order_d = config_q[DCFG_BYTE_ORDER_SELECT] & config_q[DCFG_WORD_TRANSFER_SELECT];
		dual_d = !config_q[DCFG_LONG_ADDRESS_SELECT];
		// upper address only leaves the chip in 32-bit mode
		upper_d = config_q[DCFG_LONG_ADDRESS_SELECT] ? remote_start_q : 16'h0000;
		loopback_d = !config_q[DCFG_LOOPBACK_SELECT];
		// loopback mode needs both a cleared select bit and a non-normal field
		lb_mode_d = config_q[DCFG_LOOPBACK_SELECT] ? DCFG_LB_NORMAL : lb_field_q;
		endec_d = !config_q[DCFG_LOOPBACK_SELECT] && (lb_field_q == DCFG_LB_ENDEC);
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			wr_st_q <= DCFG_WR_COLLECT;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bresp_q <= DCFG_RESP_OKAY;
			rd_st_q <= DCFG_RD_IDLE;
			rdata_q <= 32'h0000_0000;
			rresp_q <= DCFG_RESP_OKAY;
			aw_ready_q <= 1'b1;
			w_ready_q <= 1'b1;
			bvalid_q <= 1'b0;
			ar_ready_q <= 1'b1;
			rvalid_q <= 1'b0;
			config_q <= DCFG_DATA_CONFIG_RST[6:0];
			lb_field_q <= DCFG_LOOPBACK_RST;
			remote_start_q <= DCFG_REMOTE_START_RST;
			send_ignored_q <= 1'b0;
			auto_init_q <= 1'b0;
			word_mode_q <= 1'b0;
			byte_order_q <= 1'b0;
			dual_q <= 1'b0;
			upper_q <= 16'h0000;
			loopback_q <= 1'b0;
			lb_mode_q <= DCFG_LB_NORMAL;
			endec_q <= 1'b0;
		end else begin
			wr_st_q <= wr_st_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			aw_addr_q <= aw_addr_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bresp_q <= bresp_d;
			rd_st_q <= rd_st_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			aw_ready_q <= aw_ready_d;
			w_ready_q <= w_ready_d;
			bvalid_q <= bvalid_d;
			ar_ready_q <= ar_ready_d;
			rvalid_q <= rvalid_d;
			config_q <= config_d;
			lb_field_q <= lb_field_d;
			remote_start_q <= remote_start_d;
			send_ignored_q <= send_ignored_d;
			auto_init_q <= auto_init_d;
			word_mode_q <= word_mode_d;
			byte_order_q <= byte_order_d;
			dual_q <= dual_d;
			upper_q <= upper_d;
			loopback_q <= loopback_d;
			lb_mode_q <= lb_mode_d;
			endec_q <= endec_d;
		end
	end

	dcfg_threshold u_threshold (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.fifo_threshold_i(config_q[DCFG_FIFO_THRESHOLD_HIGH:DCFG_FIFO_THRESHOLD_LOW]),
		.word_mode_i(config_q[DCFG_WORD_TRANSFER_SELECT]),
		.rx_active_i(RX_ACTIVE_I),
		.fifo_bytes_i(FIFO_BYTES_I),
		.bus_request_o(bus_request)
	);

	dcfg_lane_steer u_lane_steer (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.word_mode_i(config_q[DCFG_WORD_TRANSFER_SELECT]),
		.byte_order_i(config_q[DCFG_BYTE_ORDER_SELECT]),
		.data_i(DMA_DATA_I),
		.lanes_o(MEM_DATA_O)
	);

	// a taken item drops its ready in the next cycle
	assign AXI_AWREADY_O = aw_ready_q;
	assign AXI_WREADY_O = w_ready_q;
	assign AXI_BVALID_O = bvalid_q;
	assign AXI_BRESP_O = bresp_q;
	assign AXI_ARREADY_O = ar_ready_q;
	assign AXI_RVALID_O = rvalid_q;
	assign AXI_RDATA_O = rdata_q;
	assign AXI_RRESP_O = rresp_q;
	assign BUS_REQUEST_O = bus_request;
	assign WORD_MODE_O = word_mode_q;
	assign BYTE_ORDER_O = byte_order_q;
	assign DUAL_CHANNEL_O = dual_q;
	assign UPPER_ADDR_O = upper_q;
	assign AUTO_INIT_O = auto_init_q;
	assign LOOPBACK_O = loopback_q;
	assign LOOPBACK_MODE_O = lb_mode_q;
	assign ENDEC_LOOPBACK_O = endec_q;

endmodule : dcfg_top

// ==== verilog/dcfg_pkg.sv ====
// dcfg_pkg: register map, field positions, reset values and encodings
// for the data configuration block.
// assumes a 32-bit AXI4-Lite register port with byte addresses.
package dcfg_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] DCFG_IDX_DATA_CONFIG = 8'h0e;
	localparam logic [7:0] DCFG_IDX_XMIT_CONFIG = 8'h0d;
	localparam logic [7:0] DCFG_IDX_REMOTE_START = 8'h10;
	localparam logic [7:0] DCFG_IDX_COMMAND = 8'h11;
	localparam logic [7:0] DCFG_IDX_STATUS = 8'h12;
	localparam int DCFG_ADDR_W = 8;

	// data_configuration fields
	localparam int DCFG_WORD_TRANSFER_SELECT = 0;
	localparam int DCFG_BYTE_ORDER_SELECT = 1;
	localparam int DCFG_LONG_ADDRESS_SELECT = 2;
	localparam int DCFG_LOOPBACK_SELECT = 3;
	localparam int DCFG_AUTO_INIT_REMOTE = 4;
	localparam int DCFG_FIFO_THRESHOLD_LOW = 5;
	localparam int DCFG_FIFO_THRESHOLD_HIGH = 6;
	localparam logic [7:0] DCFG_DATA_CONFIG_RST = 8'h04;
	localparam logic [6:0] DCFG_DATA_CONFIG_MASK = 7'h7f;

	// transmit_config_register loopback field
	localparam int DCFG_LOOPBACK_FIELD_LOW = 1;
	localparam int DCFG_LOOPBACK_FIELD_HIGH = 2;
	localparam logic [1:0] DCFG_LOOPBACK_RST = 2'h0;
	localparam logic [1:0] DCFG_LB_NORMAL = 2'h0;
	localparam logic [1:0] DCFG_LB_CONTROLLER = 2'h1;
	localparam logic [1:0] DCFG_LB_ENDEC = 2'h2;
	localparam logic [1:0] DCFG_LB_EXTERNAL = 2'h3;

	// command and status fields
	localparam int DCFG_CMD_SEND = 0;
	localparam int DCFG_ST_SEND_IGNORED = 0;
	localparam int DCFG_ST_BUS_REQUEST = 1;
	localparam int DCFG_ST_LOOPBACK = 2;
	localparam int DCFG_ST_CONFIG_LSB = 8;
	localparam logic [15:0] DCFG_REMOTE_START_RST = 16'h0000;

	// AXI responses
	localparam logic [1:0] DCFG_RESP_OKAY = 2'h0;
	localparam logic [1:0] DCFG_RESP_SLVERR = 2'h2;

	// fifo threshold in transfer units (words in word mode, bytes otherwise)
	function automatic logic [4:0] dcfg_threshold(input logic [1:0] ft, input logic word_mode);
		logic [4:0] t;
		t = 5'h00;
		case (ft)
			2'h0: t = word_mode ? 5'h01 : 5'h02;
			2'h1: t = word_mode ? 5'h02 : 5'h04;
			2'h2: t = word_mode ? 5'h04 : 5'h08;
			default: t = word_mode ? 5'h06 : 5'h0c;
		endcase
		return t;
	endfunction : dcfg_threshold

endpackage : dcfg_pkg

// ==== verilog/dcfg_threshold.sv ====
// dcfg_threshold: raises the bus request once the receive fifo holds
// the programmed threshold.
// assumes the fifo level is counted in bytes and is synchronous to CLK.
`timescale 1ns/100ps
module dcfg_threshold
	import dcfg_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// configuration
	input wire logic [1:0] fifo_threshold_i,
	input wire logic word_mode_i,
	// fifo state
	input wire logic rx_active_i,
	input wire logic [4:0] fifo_bytes_i,
	// request
	output logic bus_request_o
);
	logic bus_request_d;
	logic bus_request_q;
	logic [4:0] level;

	always_comb begin
		// word mode counts whole words only; a half word does not count
		level = word_mode_i ? {1'b0, fifo_bytes_i[4:1]} : fifo_bytes_i;
		bus_request_d = rx_active_i && (level >= dcfg_threshold(fifo_threshold_i, word_mode_i));
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_request_q <= 1'b0;
		end else begin
			bus_request_q <= bus_request_d;
		end
	end

	assign bus_request_o = bus_request_q;

endmodule : dcfg_threshold

// ==== verilog/dcfg_lane_steer.sv ====
// dcfg_lane_steer: places DMA data on the memory data lanes.
// assumes input data as {most significant byte, least significant byte}.
`timescale 1ns/100ps
module dcfg_lane_steer
	import dcfg_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// configuration
	input wire logic word_mode_i,
	input wire logic byte_order_i,
	// data
	input wire logic [15:0] data_i,
	output logic [15:0] lanes_o
);
	logic [15:0] lanes_d;
	logic [15:0] lanes_q;

	always_comb begin
		lanes_d = data_i;
		// byte-wide transfers always use the low lane
		if (!word_mode_i) begin
			lanes_d = {8'h00, data_i[7:0]};
		end else if (byte_order_i) begin
			lanes_d = {data_i[7:0], data_i[15:8]};
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lanes_q <= 16'h0000;
		end else begin
			lanes_q <= lanes_d;
		end
	end

	assign lanes_o = lanes_q;

endmodule : dcfg_lane_steer

// ==== sim/dcfg_chk.sv ====
// dcfg_chk: port-level assertions for dcfg_top.
// assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module dcfg_chk
	import dcfg_pkg::*;
(
	// clock, reset and bus handshakes
	input logic CLK_I, RSTN_I,
	input logic AXI_AWVALID_I, AXI_AWREADY_O, AXI_WVALID_I, AXI_WREADY_O, AXI_BVALID_O,
	input logic AXI_ARVALID_I, AXI_ARREADY_O, AXI_RVALID_O,
	// fifo, mode and lane signals
	input logic RX_ACTIVE_I, BUS_REQUEST_O, WORD_MODE_O, BYTE_ORDER_O, DUAL_CHANNEL_O,
	input logic AUTO_INIT_O, LOOPBACK_O, ENDEC_LOOPBACK_O,
	input logic [4:0] FIFO_BYTES_I,
	input logic [1:0] LOOPBACK_MODE_O,
	input logic [15:0] UPPER_ADDR_O, DMA_DATA_I, MEM_DATA_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	wire [1:0] md = {WORD_MODE_O, BYTE_ORDER_O};
	logic [15:0] dq;
	always_ff @(posedge CLK_I) dq <= DMA_DATA_I;
	// mode held two cycles, so either mode copy may feed the lanes
	property lane_p(m, e);
		$past(RSTN_I) && $past(RSTN_I, 2) && md == m && md == $past(md) && md == $past(md, 2)
			|-> MEM_DATA_O == e;
	endproperty
	AST_BUS_REQUEST_IDLE: assert property (!RX_ACTIVE_I |=> !BUS_REQUEST_O)
		else $error("bus request while idle");
	AST_BUS_REQUEST_FULL: assert property (RX_ACTIVE_I && FIFO_BYTES_I >= 5'd12 |=> BUS_REQUEST_O)
		else $error("no bus request at full threshold");
	AST_BUS_REQUEST_MIN: assert property (BUS_REQUEST_O |-> $past(FIFO_BYTES_I) >= 5'd2)
		else $error("bus request below least threshold");
	AST_BOS_WORD: assert property (BYTE_ORDER_O |-> WORD_MODE_O)
		else $error("byte order active in byte mode");
	AST_LANE_BYTE: assert property (lane_p(2'b00, {8'h00, dq[7:0]}))
		else $error("byte mode lanes");
	AST_LANE_WORD: assert property (lane_p(2'b10, dq))
		else $error("word mode lanes");
	AST_LANE_SWAP: assert property (lane_p(2'b11, {dq[7:0], dq[15:8]}))
		else $error("swapped lanes");
	AST_DUAL_UPPER: assert property (DUAL_CHANNEL_O |-> UPPER_ADDR_O == 16'h0000)
		else $error("upper address in dual mode");
	AST_LB_MODE: assert property (!LOOPBACK_O |-> LOOPBACK_MODE_O == DCFG_LB_NORMAL)
		else $error("loopback mode in normal operation");
	AST_ENDEC: assert property (ENDEC_LOOPBACK_O == (LOOPBACK_O && LOOPBACK_MODE_O == DCFG_LB_ENDEC))
		else $error("endec loopback mismatch");
	AST_AUTO_PULSE: assert property (AUTO_INIT_O |-> $rose(AXI_BVALID_O) ##1 !AUTO_INIT_O)
		else $error("auto init pulse");
	AST_B_TIMING: assert property (AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O
		|=> !AXI_BVALID_O ##1 AXI_BVALID_O)
		else $error("write response timing");
	AST_R_TIMING: assert property (AXI_ARVALID_I && AXI_ARREADY_O |=> AXI_RVALID_O && !AXI_ARREADY_O)
		else $error("read response timing");
	AST_RESET_LAS: assert property ($past(RSTN_I) && !$past(RSTN_I, 2) |-> !DUAL_CHANNEL_O && LOOPBACK_O)
		else $error("reset mode");
	COV_AUTO: cover property (AUTO_INIT_O);
	COV_BUS_REQUEST: cover property ($rose(BUS_REQUEST_O));
	COV_ENDEC: cover property (ENDEC_LOOPBACK_O);
endmodule : dcfg_chk

bind dcfg_top dcfg_chk chk_u (.*);

// ==== sim/dcfg_fifo_model.sv ====
// dcfg_fifo_model: receive fifo and DMA data source beside dcfg_top.
// assumes the bench starts and stops reception with run_i.
`timescale 1ns/100ps
module dcfg_fifo_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// bench control
	input wire logic run_i,
	// fifo side of the block
	output logic rx_active_o,
	output logic [4:0] fifo_bytes_o,
	output logic [15:0] dma_data_o
);
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_active_o <= 1'b0;
			fifo_bytes_o <= 5'h00;
			dma_data_o <= 16'h0000;
		end else begin
			rx_active_o <= run_i;
			// one byte a cycle from the network, full at 16
			fifo_bytes_o <= !run_i ? 5'h00 : fifo_bytes_o + 5'(fifo_bytes_o != 5'h10);
			// changes every cycle so a stale lane never matches
			dma_data_o <= dma_data_o + 16'h1357;
		end
	end
endmodule : dcfg_fifo_model

// ==== sim/tb_dcfg_top.sv ====
// tb_dcfg_top: directed bench for dcfg_top with fifo model and checker.
// assumes the checker is bound from its own file.
`timescale 1ns/100ps
module tb_dcfg_top
	import dcfg_pkg::*;
	;
	logic CLK_I = 1'b0;
	logic RSTN_I;
	logic [7:0] AXI_AWADDR_I = 8'h00, AXI_ARADDR_I = 8'h00;
	logic [31:0] AXI_WDATA_I = 32'h0, AXI_RDATA_O, rd;
	logic [3:0] AXI_WSTRB_I = 4'hf;
	logic AXI_AWVALID_I = 1'b0, AXI_WVALID_I = 1'b0, AXI_BREADY_I = 1'b0;
	logic AXI_ARVALID_I = 1'b0, AXI_RREADY_I = 1'b0, run = 1'b0;
	logic AXI_AWREADY_O, AXI_WREADY_O, AXI_BVALID_O, AXI_ARREADY_O, AXI_RVALID_O;
	logic [1:0] AXI_BRESP_O, AXI_RRESP_O, LOOPBACK_MODE_O, rsp;
	logic RX_ACTIVE_I, BUS_REQUEST_O, WORD_MODE_O, BYTE_ORDER_O, DUAL_CHANNEL_O;
	logic AUTO_INIT_O, LOOPBACK_O, ENDEC_LOOPBACK_O;
	logic [4:0] FIFO_BYTES_I;
	logic [15:0] UPPER_ADDR_O, DMA_DATA_I, MEM_DATA_O;
	int errors = 0, checks = 0, pulses = 0;

	dcfg_top dut_u (.*);
	dcfg_fifo_model fifo_u (.clk_i(CLK_I), .rstn_i(RSTN_I), .run_i(run),
		.rx_active_o(RX_ACTIVE_I), .fifo_bytes_o(FIFO_BYTES_I), .dma_data_o(DMA_DATA_I));

	initial begin
		forever #5 CLK_I = ~CLK_I;
	end
	always @(posedge CLK_I) if (AUTO_INIT_O) pulses++;

	task automatic finish_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic hang(input string n);
		errors++;
		$display("Error %s timed out", n);
		finish_test;
	endtask : hang
	function automatic logic [7:0] ad(input logic [7:0] i);
		return i << 2;
	endfunction : ad
	task automatic axw(input logic [7:0] i, input logic [31:0] d);
		bit got;
		got = 0;
		@(posedge CLK_I);
		AXI_AWADDR_I <= ad(i);
		AXI_WDATA_I <= d;
		AXI_AWVALID_I <= 1'b1;
		AXI_WVALID_I <= 1'b1;
		AXI_BREADY_I <= 1'b1;
		for (int n = 0; n < 40 && !got; n++) begin
			@(posedge CLK_I);
			if (AXI_AWVALID_I && AXI_AWREADY_O) AXI_AWVALID_I <= 1'b0;
			if (AXI_WVALID_I && AXI_WREADY_O) AXI_WVALID_I <= 1'b0;
			if (AXI_BVALID_O && AXI_BREADY_I) begin
				rsp = AXI_BRESP_O;
				AXI_BREADY_I <= 1'b0;
				got = 1;
			end
		end
		if (!got) hang("write");
	endtask : axw
	task automatic axr(input logic [7:0] i);
		bit got;
		got = 0;
		@(posedge CLK_I);
		AXI_ARADDR_I <= ad(i);
		AXI_ARVALID_I <= 1'b1;
		AXI_RREADY_I <= 1'b1;
		for (int n = 0; n < 40 && !got; n++) begin
			@(posedge CLK_I);
			if (AXI_ARVALID_I && AXI_ARREADY_O) AXI_ARVALID_I <= 1'b0;
			if (AXI_RVALID_O && AXI_RREADY_I) begin
				rd = AXI_RDATA_O;
				rsp = AXI_RRESP_O;
				AXI_RREADY_I <= 1'b0;
				got = 1;
			end
		end
		if (!got) hang("read");
	endtask : axr
	task automatic st;
		repeat (2) @(posedge CLK_I);
		#1;
	endtask : st

	task automatic t_reset;
		chk("dual", 0, DUAL_CHANNEL_O);
		chk("loopback", 1, LOOPBACK_O);
		axr(DCFG_IDX_STATUS);
		chk("config readback", 32'h04, (rd >> DCFG_ST_CONFIG_LSB) & 32'h7f);
		axr(DCFG_IDX_DATA_CONFIG);
		chk("write only read", 0, rd);
		axw(8'h3f, 32'h1);
		chk("unmapped resp", DCFG_RESP_SLVERR, rsp);
	endtask : t_reset
	task automatic t_upper;
		axw(DCFG_IDX_DATA_CONFIG, 32'h0c);
		axw(DCFG_IDX_REMOTE_START, 32'h0000a5c3);
		chk("write resp", DCFG_RESP_OKAY, rsp);
		st;
		chk("upper addr", 16'ha5c3, UPPER_ADDR_O);
		axr(DCFG_IDX_REMOTE_START);
		chk("remote start", 32'ha5c3, rd);
		chk("read resp", DCFG_RESP_OKAY, rsp);
		// only the high byte lane is enabled, low byte must survive
		AXI_WSTRB_I <= 4'h2;
		axw(DCFG_IDX_REMOTE_START, 32'h0000_5a5a);
		AXI_WSTRB_I <= 4'hf;
		axr(DCFG_IDX_REMOTE_START);
		chk("remote start strb", 32'h5ac3, rd);
		axw(DCFG_IDX_DATA_CONFIG, 32'h08);
		st;
		chk("dual", 1, DUAL_CHANNEL_O);
		chk("upper dual", 0, UPPER_ADDR_O);
		chk("normal", 0, LOOPBACK_O);
	endtask : t_upper
	task automatic t_loop;
		axw(DCFG_IDX_DATA_CONFIG, 32'h04);
		for (int m = 0; m < 4; m++) begin
			axw(DCFG_IDX_XMIT_CONFIG, 32'(m) << DCFG_LOOPBACK_FIELD_LOW);
			st;
			chk("loopback mode", m, LOOPBACK_MODE_O);
			chk("endec", m == 2, ENDEC_LOOPBACK_O);
		end
		axr(DCFG_IDX_STATUS);
		chk("status loopback", 1, rd[DCFG_ST_LOOPBACK]);
		axw(DCFG_IDX_DATA_CONFIG, 32'h0c);
		st;
		chk("mode normal", DCFG_LB_NORMAL, LOOPBACK_MODE_O);
	endtask : t_loop
	task automatic t_send;
		int p;
		for (int a = 1; a >= 0; a--) begin
			axw(DCFG_IDX_DATA_CONFIG, 32'h0c | (32'(a) << DCFG_AUTO_INIT_REMOTE));
			p = pulses;
			axw(DCFG_IDX_COMMAND, 32'h1 << DCFG_CMD_SEND);
			st;
			chk("auto pulses", a, pulses - p);
			axr(DCFG_IDX_STATUS);
			chk("send ignored", !a, rd[DCFG_ST_SEND_IGNORED]);
		end
		axw(DCFG_IDX_STATUS, 32'h1);
		axr(DCFG_IDX_STATUS);
		chk("ignored clear", 0, rd[DCFG_ST_SEND_IGNORED]);
	endtask : t_send
	task automatic t_thr;
		int n;
		logic [4:0] tab [4] = '{5'd2, 5'd4, 5'd8, 5'd12};
		for (int w = 0; w < 2; w++) for (int f = 0; f < 4; f++) begin
			axw(DCFG_IDX_DATA_CONFIG, 32'h0c | w | (f << DCFG_FIFO_THRESHOLD_LOW));
			@(posedge CLK_I);
			run <= 1'b1;
			n = 0;
			do begin
				@(posedge CLK_I);
				n++;
			end while (BUS_REQUEST_O !== 1'b1 && n < 30);
			if (n == 30) hang("bus request");
			// request lags the fill by one cycle, one more byte arrived
			chk("fill at request", tab[f] + 1, FIFO_BYTES_I);
			axr(DCFG_IDX_STATUS);
			chk("status request", 1, rd[DCFG_ST_BUS_REQUEST]);
			run <= 1'b0;
			repeat (3) @(posedge CLK_I);
		end
	endtask : t_thr
	task automatic t_lanes;
		logic [15:0] d, e;
		logic [7:0] cf [3] = '{8'h0d, 8'h0f, 8'h0e};
		for (int i = 0; i < 3; i++) begin
			axw(DCFG_IDX_DATA_CONFIG, cf[i]);
			st;
			d = DMA_DATA_I;
			@(posedge CLK_I);
			#1;
			e = cf[i][0] ? (cf[i][1] ? {d[7:0], d[15:8]} : d) : {8'h00, d[7:0]};
			chk("lanes", e, MEM_DATA_O);
			chk("word mode", cf[i][0], WORD_MODE_O);
			chk("byte order", cf[i] == 8'h0f, BYTE_ORDER_O);
		end
	endtask : t_lanes

	initial begin
		RSTN_I = 1'b0;
		repeat (5) @(posedge CLK_I);
		RSTN_I <= 1'b1;
		repeat (3) @(posedge CLK_I);
		#1;
		t_reset;
		t_upper;
		t_loop;
		t_send;
		t_thr;
		t_lanes;
		finish_test;
	end
endmodule : tb_dcfg_top
